// [inc/pgfs_pkg.sv]
// Package with register map and reset values for the port one block
package pgfs_pkg;
   localparam int ADDR_W = 4;
   // Word registers on classic Wishbone, byte address
   localparam logic [3:0] OFS_FUNC_SEL = 4'h0;
   localparam logic [3:0] OFS_DIRECTION = 4'h4;
   localparam logic [3:0] OFS_OUT_LATCH = 4'h8;
   // Field positions in the function-select register
   localparam int FS_TIMER_CLK = 0;
   localparam int FS_SERIAL_TX = 1;
   localparam int FS_EXT_INT0 = 4;
   localparam int FS_EXT_INT1 = 5;
   localparam int FS_EXT_INT2 = 6;
   localparam int FS_EXT_INT3 = 7;
   // Reserved bit positions
   localparam int RSV_BIT = 3;
   localparam logic [7:0] FS_RSV_MASK = 8'h0C;
   localparam logic [7:0] PORT_RSV_MASK = 8'h08;
   // Writable bits of each register
   localparam logic [7:0] FS_WR_MASK = 8'hF3;
   localparam logic [7:0] PORT_WR_MASK = 8'hF7;
   // Values after reset
   localparam logic [7:0] FS_RESET = 8'h00;
   localparam logic [7:0] DIR_RESET = 8'h00;
   localparam logic [7:0] LATCH_RESET = 8'h00;
   localparam logic [7:0] SYNC_RESET = 8'h00;
   // Read value of the write-only direction register
   localparam logic [31:0] WO_READ = 32'h0000_0000;
endpackage

// [inc/pgfs_sync_if.sv]
// Interface carrying raw and synchronised pin levels
`timescale 1ns/100ps
interface pgfs_sync_if;
   logic [7:0] raw;
   logic [7:0] sync;
   modport owner (output raw, input sync);
   modport sync_side (input raw, output sync);
endinterface

// [hdl/pgfs_sync.sv]
// Two-stage synchroniser for the port one pin levels
`timescale 1ns/100ps
module pgfs_sync
(
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   pgfs_sync_if.sync_side bus
);
   logic [7:0] stage_one;
   logic [7:0] stage_two;

   // First stage is read only by the second stage
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_reset_n)
      begin
         stage_one <= pgfs_pkg::SYNC_RESET;
         stage_two <= pgfs_pkg::SYNC_RESET;
      end
      else
      begin
         stage_one <= bus.raw;
         stage_two <= stage_one;
      end
   end

   assign bus.sync = stage_two;
endmodule // pgfs_sync

// [hdl/pgfs_port_one.sv]
// Port one GPIO with function select behind a classic Wishbone slave
//
// Local design decisions: the placing of the registers and register access over Wishbone.
`timescale 1ns/100ps
// Contract
// - Select bit 7 routes pin seven to int3/trigger
// - Select bit 6 routes pin six to int2
// - Select bit 5 routes pin five to int1
// - Select bit 4 routes pin four to int0
// - Select bit 1 drives port-two pin two serial
// - Select bit 0 drives pin zero timer clock
// - Select bits 3 and 2 read as one
// - Direction one drives pin, zero makes input
// - Direction per pin, write-only, bit 3 unused
// - Latch holds output value, written bitwise
// - Output pins read back latch value
// - Input pins read back live pin level
// - Latch bit 3 reads as one
// - All functional bits reset to zero
// - Direction ignored by pin enables while function selected; read-back still follows direction
module pgfs_port_one
(
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [pgfs_pkg::ADDR_W-1:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   output logic o_wb_err,
   input wire logic [7:0] i_pin,
   output logic [7:0] o_pin,
   output logic [7:0] o_pin_oe,
   input wire logic i_serial_tx,
   input wire logic i_timer_clock_output,
   input wire logic i_port_two_pin_two_out,
   input wire logic i_port_two_pin_two_oe,
   output logic o_port_two_pin_two,
   output logic o_port_two_pin_two_oe,
   output logic o_ext_int_zero_pin,
   output logic o_ext_int_one_pin,
   output logic o_ext_int_two_pin,
   output logic o_ext_int_three_pin,
   output logic o_timer_trigger_input
);
   logic [7:0] port_one_function_select;
   logic [7:0] port_one_direction;
   logic [7:0] port_one_output_latch;
   logic [7:0] pin_level;
   logic [7:0] next_pin;
   logic [7:0] next_oe;
   logic [31:0] next_rdata;
   logic req;
   logic hit;
   logic wr_fire;

   pgfs_sync_if sync_bus ();

   // Merge byte-lane zero into a register, keeping fixed bits
   function automatic logic [7:0] merge_byte(input logic [7:0] cur,
      input logic [7:0] data, input logic lane, input logic [7:0] wmask);
      merge_byte = lane ? ((cur & ~wmask) | (data & wmask)) : cur;
   endfunction

   assign sync_bus.raw = i_pin;
   assign pin_level = sync_bus.sync;

   pgfs_sync u_sync
   (
      .i_ref_clk (i_ref_clk),
      .i_reset_n (i_reset_n),
      .bus (sync_bus.sync_side)
   );

   // One-cycle ack; ack low in the cycle after it so requests do not repeat
   assign req = i_wb_cyc && i_wb_stb && !o_wb_ack && !o_wb_err;
   assign hit = (i_wb_adr == pgfs_pkg::OFS_FUNC_SEL)
      || (i_wb_adr == pgfs_pkg::OFS_DIRECTION)
      || (i_wb_adr == pgfs_pkg::OFS_OUT_LATCH);
   assign wr_fire = req && hit && i_wb_we;

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_reset_n)
      begin
         o_wb_ack <= 1'b0;
         o_wb_err <= 1'b0;
      end
      else
      begin
         o_wb_ack <= req && hit;
         o_wb_err <= req && !hit;
      end
   end

   // Function select register
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_reset_n)
      begin
         port_one_function_select <= pgfs_pkg::FS_RESET;
      end
      else if (wr_fire && i_wb_adr == pgfs_pkg::OFS_FUNC_SEL)
      begin
         port_one_function_select <= merge_byte(port_one_function_select,
            i_wb_dat[7:0], i_wb_sel[0], pgfs_pkg::FS_WR_MASK);
      end
   end

   // Direction register; bit 3 is never stored
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_reset_n)
      begin
         port_one_direction <= pgfs_pkg::DIR_RESET;
      end
      else if (wr_fire && i_wb_adr == pgfs_pkg::OFS_DIRECTION)
      begin
         port_one_direction <= merge_byte(port_one_direction,
            i_wb_dat[7:0], i_wb_sel[0], pgfs_pkg::PORT_WR_MASK);
      end
   end

   // Output latch
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_reset_n)
      begin
         port_one_output_latch <= pgfs_pkg::LATCH_RESET;
      end
      else if (wr_fire && i_wb_adr == pgfs_pkg::OFS_OUT_LATCH)
      begin
         port_one_output_latch <= merge_byte(port_one_output_latch,
            i_wb_dat[7:0], i_wb_sel[0], pgfs_pkg::PORT_WR_MASK);
      end
   end

   // Read mux
   always_comb
   begin
      next_rdata = 32'h0000_0000;
      if (i_wb_adr == pgfs_pkg::OFS_FUNC_SEL)
      begin
         next_rdata[7:0] = port_one_function_select
            | pgfs_pkg::FS_RSV_MASK;
      end
      else if (i_wb_adr == pgfs_pkg::OFS_DIRECTION)
      begin
         next_rdata = pgfs_pkg::WO_READ;
      end
      else if (i_wb_adr == pgfs_pkg::OFS_OUT_LATCH)
      begin
         // Live level only after two-stage sync, so reads lag pins
         next_rdata[7:0] = (port_one_direction & port_one_output_latch)
            | (~port_one_direction & pin_level)
            | pgfs_pkg::PORT_RSV_MASK;
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_reset_n)
      begin
         o_wb_dat <= 32'h0000_0000;
      end
      else if (req)
      begin
         o_wb_dat <= hit ? next_rdata : 32'h0000_0000;
      end
   end

   // Pin drivers
   always_comb
   begin
      next_pin = port_one_output_latch;
      next_oe = port_one_direction & pgfs_pkg::PORT_WR_MASK;
      // Selected input functions tri-state the pin regardless of direction
      next_oe[7:4] = port_one_direction[7:4]
         & ~port_one_function_select[7:4];
      if (port_one_function_select[pgfs_pkg::FS_TIMER_CLK])
      begin
         next_pin[0] = i_timer_clock_output;
         next_oe[0] = 1'b1;
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_reset_n)
      begin
         o_pin <= 8'h00;
         o_pin_oe <= 8'h00;
      end
      else
      begin
         o_pin <= next_pin;
         o_pin_oe <= next_oe;
      end
   end

   // Neighbouring port pin two handed to the serial transmitter
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_reset_n)
      begin
         o_port_two_pin_two <= 1'b0;
         o_port_two_pin_two_oe <= 1'b0;
      end
      else if (port_one_function_select[pgfs_pkg::FS_SERIAL_TX])
      begin
         o_port_two_pin_two <= i_serial_tx;
         o_port_two_pin_two_oe <= 1'b1;
      end
      else
      begin
         o_port_two_pin_two <= i_port_two_pin_two_out;
         o_port_two_pin_two_oe <= i_port_two_pin_two_oe;
      end
   end

   // Function inputs idle high when deselected, as active-low interrupts
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_reset_n)
      begin
         o_ext_int_zero_pin <= 1'b1;
         o_ext_int_one_pin <= 1'b1;
         o_ext_int_two_pin <= 1'b1;
         o_ext_int_three_pin <= 1'b1;
         o_timer_trigger_input <= 1'b1;
      end
      else
      begin
         o_ext_int_zero_pin <= port_one_function_select[pgfs_pkg::FS_EXT_INT0]
            ? pin_level[4] : 1'b1;
         o_ext_int_one_pin <= port_one_function_select[pgfs_pkg::FS_EXT_INT1]
            ? pin_level[5] : 1'b1;
         o_ext_int_two_pin <= port_one_function_select[pgfs_pkg::FS_EXT_INT2]
            ? pin_level[6] : 1'b1;
         o_ext_int_three_pin <=
            port_one_function_select[pgfs_pkg::FS_EXT_INT3]
            ? pin_level[7] : 1'b1;
         o_timer_trigger_input <=
            port_one_function_select[pgfs_pkg::FS_EXT_INT3]
            ? pin_level[7] : 1'b1;
      end
   end

   property p_fs_read_rsv;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      (req && !i_wb_we && i_wb_adr == pgfs_pkg::OFS_FUNC_SEL)
      |=> (o_wb_ack && o_wb_dat[3:2] == 2'b11);
   endproperty
   a_fs_read_rsv: assert property (p_fs_read_rsv)
      else $error("Reserved select bits not read as one");

   property p_latch_rsv;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      (req && !i_wb_we && i_wb_adr == pgfs_pkg::OFS_OUT_LATCH)
      |=> o_wb_dat[3];
   endproperty
   a_latch_rsv: assert property (p_latch_rsv)
      else $error("Latch bit 3 not read as one");

   property p_read_out;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      (req && !i_wb_we && i_wb_adr == pgfs_pkg::OFS_OUT_LATCH
         && port_one_direction[0])
      |=> o_wb_dat[0] == $past(port_one_output_latch[0]);
   endproperty
   a_read_out: assert property (p_read_out)
      else $error("Output pin read did not return latch");

   property p_read_in;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      (req && !i_wb_we && i_wb_adr == pgfs_pkg::OFS_OUT_LATCH
         && !port_one_direction[1])
      |=> o_wb_dat[1] == $past(i_pin[1], 3);
   endproperty
   a_read_in: assert property (p_read_in)
      else $error("Input pin read did not return pin level");

   property p_dir_read_zero;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      (req && !i_wb_we && i_wb_adr == pgfs_pkg::OFS_DIRECTION)
      |=> o_wb_dat == 32'h0000_0000;
   endproperty
   a_dir_read_zero: assert property (p_dir_read_zero)
      else $error("Direction register read not zero");

   property p_fs_oe;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      port_one_function_select[pgfs_pkg::FS_EXT_INT0] |=> !o_pin_oe[4];
   endproperty
   a_fs_oe: assert property (p_fs_oe)
      else $error("Pin four driven while used as interrupt");

   property p_tmr_clk;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      port_one_function_select[0]
      |=> (o_pin_oe[0] && o_pin[0] == $past(i_timer_clock_output));
   endproperty
   a_tmr_clk: assert property (p_tmr_clk)
      else $error("Timer clock not driven on pin zero");

   property p_drive_latch;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      (port_one_direction[2] && !port_one_function_select[0])
      |=> (o_pin_oe[2] && o_pin[2] == $past(port_one_output_latch[2]));
   endproperty
   a_drive_latch: assert property (p_drive_latch)
      else $error("Output pin not driven from latch");

   property p_trig_route;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      port_one_function_select[pgfs_pkg::FS_EXT_INT3]
      |=> (o_timer_trigger_input == $past(pin_level[7])
         && o_ext_int_three_pin == $past(pin_level[7]));
   endproperty
   a_trig_route: assert property (p_trig_route)
      else $error("Pin seven not routed to interrupt and trigger");

   property p_int1_route;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      port_one_function_select[pgfs_pkg::FS_EXT_INT1]
      |=> o_ext_int_one_pin == $past(pin_level[5]);
   endproperty
   a_int1_route: assert property (p_int1_route)
      else $error("Pin five not routed to interrupt one");

   property p_serial_route;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      port_one_function_select[pgfs_pkg::FS_SERIAL_TX]
      |=> (o_port_two_pin_two_oe
         && o_port_two_pin_two == $past(i_serial_tx));
   endproperty
   a_serial_route: assert property (p_serial_route)
      else $error("Serial transmit not driven on port two pin two");

   property p_gpio_oe;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      !port_one_function_select[pgfs_pkg::FS_EXT_INT1]
      |=> o_pin_oe[5] == $past(port_one_direction[5]);
   endproperty
   a_gpio_oe: assert property (p_gpio_oe)
      else $error("General pin five enable does not follow direction");
endmodule // pgfs_port_one

// [tb/pgfs_pins_model.sv]
// Pin and peripheral side model for the port one block
`timescale 1ns/100ps
module pgfs_pins_model
(
   input wire logic [7:0] i_pin_out,
   input wire logic [7:0] i_pin_oe,
   input wire logic [7:0] i_ext_drive,
   output logic [7:0] o_pin_level
);
   // Driven pins show the block's value; released pins follow the board
   always_comb
   begin
      o_pin_level = (i_pin_oe & i_pin_out) | (~i_pin_oe & i_ext_drive);
   end
endmodule // pgfs_pins_model

// [tb/tb_port1_gpio_with_function_select.sv]
// Self-checking bench for the port one GPIO block
`timescale 1ns/100ps
module tb_port1_gpio_with_function_select;
   logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [3:0] adr = 4'h0, sel = 4'h0;
   logic [31:0] wdat = 32'h0, rdat;
   logic ack, err, tx = 1'b0, tclk = 1'b0, p2o = 1'b0, p2oe = 1'b0;
   logic p2, p2e, i0, i1, i2, i3, trg;
   logic [7:0] pin, opin, oe, ext = 8'h00, q;
   logic e;
   logic [3:0] wsel = 4'hF;
   int errors = 0, checks = 0, cycles = 0;
   pgfs_port_one DUT (.i_ref_clk(clk), .i_reset_n(rst_n), .i_wb_cyc(cyc),
      .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
      .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .o_wb_err(err),
      .i_pin(pin), .o_pin(opin), .o_pin_oe(oe), .i_serial_tx(tx),
      .i_timer_clock_output(tclk), .i_port_two_pin_two_out(p2o),
      .i_port_two_pin_two_oe(p2oe), .o_port_two_pin_two(p2),
      .o_port_two_pin_two_oe(p2e), .o_ext_int_zero_pin(i0),
      .o_ext_int_one_pin(i1), .o_ext_int_two_pin(i2),
      .o_ext_int_three_pin(i3), .o_timer_trigger_input(trg));
   pgfs_pins_model PINS (.i_pin_out(opin), .i_pin_oe(oe),
      .i_ext_drive(ext), .o_pin_level(pin));
   initial
   begin
      forever #4 clk = ~clk;
   end
   task automatic wrap_up();
      if (errors == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Hang guard, far above the fewer than a hundred cycles the run needs
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         errors++;
         wrap_up();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp)
      begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Classic single cycle; request held until ack or err is sampled
   task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= wsel;
      wdat <= {24'h0, d};
      // Ack or err ends this wait; the hang guard ends it if neither comes
      do
      begin
         @(posedge clk);
      end
      while (ack !== 1'b1 && err !== 1'b1);
      q = rdat[7:0];
      e = err;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      wb(1'b0, a, 8'h00);
      chk(q, exp);
   endtask
   task automatic t_reset();
      rd(pgfs_pkg::OFS_FUNC_SEL, 8'h0C);
      rd(pgfs_pkg::OFS_DIRECTION, 8'h00);
      rd(pgfs_pkg::OFS_OUT_LATCH, 8'h08);
      chk(oe, 8'h00);
      chk({3'b0, trg, i3, i2, i1, i0}, 8'h1F);
   endtask
   task automatic t_out();
      wb(1'b1, pgfs_pkg::OFS_DIRECTION, 8'hFF);
      wb(1'b1, pgfs_pkg::OFS_OUT_LATCH, 8'hA5);
      settle(2);
      chk(oe, 8'hF7);
      chk(opin & 8'hF7, 8'hA5);
      rd(pgfs_pkg::OFS_OUT_LATCH, 8'hAD);
   endtask
   task automatic t_mixed();
      wb(1'b1, pgfs_pkg::OFS_DIRECTION, 8'hF0);
      ext <= 8'h3C;
      settle(5);
      rd(pgfs_pkg::OFS_OUT_LATCH, 8'hAC);
   endtask
   task automatic t_func();
      wb(1'b1, pgfs_pkg::OFS_FUNC_SEL, 8'hF3);
      ext <= 8'h50;
      tclk <= 1'b1;
      p2o <= 1'b1;
      settle(5);
      rd(pgfs_pkg::OFS_FUNC_SEL, 8'hFF);
      chk(oe, 8'h01);
      chk({7'h0, opin[0]}, 8'h01);
      chk({3'b0, trg, i3, i2, i1, i0}, 8'h05);
      chk({6'h0, p2e, p2}, 8'h02);
      @(posedge clk);
      tclk <= 1'b0;
      tx <= 1'b1;
      settle(3);
      chk({6'h0, p2e, p2}, 8'h03);
      chk({7'h0, opin[0]}, 8'h00);
      wb(1'b1, pgfs_pkg::OFS_FUNC_SEL, 8'h00);
      settle(5);
      chk(oe, 8'hF0);
      chk({3'b0, trg, i3, i2, i1, i0}, 8'h1F);
      chk({6'h0, p2e, p2}, 8'h01);
      @(posedge clk);
      p2oe <= 1'b1;
      settle(2);
      chk({6'h0, p2e, p2}, 8'h03);
   endtask
   // Byte lane zero off: the write must be ignored
   task automatic t_sel();
      wsel = 4'hE;
      wb(1'b1, pgfs_pkg::OFS_FUNC_SEL, 8'hFF);
      wsel = 4'hF;
      rd(pgfs_pkg::OFS_FUNC_SEL, 8'h0C);
   endtask
   // Unmapped access must be refused and change nothing
   task automatic t_err();
      wb(1'b1, 4'hC, 8'hFF);
      chk({7'h0, e}, 8'h01);
      rd(pgfs_pkg::OFS_FUNC_SEL, 8'h0C);
   endtask
   initial
   begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_out();
      t_mixed();
      t_func();
      t_err();
      t_sel();
      wrap_up();
   end
endmodule // tb_port1_gpio_with_function_select
